// >>> src/led_behavior_sequencer.sv
/*
  Six-channel LED behavior sequencer: direct, pulse once, pulse while held and breathe,
  actuated by a linked touch flag or by a drive bit, with a PWM output per LED pin.
  Assumes a register master on the same clock, and touch flags from touch logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "led_seq_defs.svh"

module led_behavior_sequencer
  import led_seq_pkg::*;
#(
  parameter int CHANNELS = 6,
  parameter int STEP_CYC = `STEP_CYCLES,
  parameter logic [6:0] MIN_PER_SETTING = 7'h01
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic [5:0] TOUCH_IN,
  output logic [5:0] LED_OUT
);

  // ==========================================================
  // helpers
  function automatic logic [6:0] max_pct(input logic [3:0] code);
    case (code)
      4'h0: max_pct = 7'd7;
      4'h1: max_pct = 7'd9;
      4'h2: max_pct = 7'd11;
      4'h3: max_pct = 7'd14;
      4'h4: max_pct = 7'd17;
      4'h5: max_pct = 7'd20;
      4'h6: max_pct = 7'd23;
      4'h7: max_pct = 7'd26;
      4'h8: max_pct = 7'd30;
      4'h9: max_pct = 7'd35;
      4'hA: max_pct = 7'd40;
      4'hB: max_pct = 7'd50;
      4'hC: max_pct = 7'd60;
      4'hD: max_pct = 7'd70;
      4'hE: max_pct = 7'd80;
      default: max_pct = 7'd100;
    endcase
  endfunction

  // the min scale is the max scale shifted down by one code
  function automatic logic [6:0] min_pct(input logic [3:0] code);
    min_pct = (code == 4'h0) ? 7'd0 : max_pct(code - 4'h1);
  endfunction

  // ==========================================================
  // registers
  logic [7:0] beh_lo_q, beh_hi_q, pulse_once_period_field_q, p2_per_q, br_per_q, cfg_q;
  logic [7:0] duty_q [4];
  logic [5:0] link_q, pol_q, drive_q;
  logic [7:0] rdata_q;
  logic [5:0] led_q;
  logic [5:0] led_d;
  logic [5:0] busy;
  logic [7:0] rdata_d;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      beh_lo_q <= `RST_BEH;
      beh_hi_q <= `RST_BEH;
      pulse_once_period_field_q <= `RST_PULSE_ONCE_PERIOD_FIELD;
      p2_per_q <= `RST_P2_PER;
      br_per_q <= `RST_BR_PER;
      cfg_q <= `RST_LED_CFG;
      for (int k = 0; k < 4; k++) begin
        duty_q[k] <= `RST_DUTY;
      end
      link_q <= `RST_CHAN;
      pol_q <= `RST_CHAN;
      drive_q <= `RST_CHAN;
    end else if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        `ADDR_BEH_LOW: beh_lo_q <= REG_WDATA_IN;
        `ADDR_BEH_HIGH: beh_hi_q <= {4'h0, REG_WDATA_IN[3:0]};
        `ADDR_PULSE_ONCE_PERIOD_FIELD: pulse_once_period_field_q <= REG_WDATA_IN;
        `ADDR_P2_PER: p2_per_q <= {1'b0, REG_WDATA_IN[`PER_MSB:0]};
        `ADDR_BR_PER: br_per_q <= {1'b0, REG_WDATA_IN[`PER_MSB:0]};
        `ADDR_LED_CFG: cfg_q <= {2'b00, REG_WDATA_IN[5:0]};
        `ADDR_DUTY_P1: duty_q[0] <= REG_WDATA_IN;
        `ADDR_DUTY_P2: duty_q[1] <= REG_WDATA_IN;
        `ADDR_DUTY_BR: duty_q[2] <= REG_WDATA_IN;
        `ADDR_DUTY_DR: duty_q[3] <= REG_WDATA_IN;
        `ADDR_LINK: link_q <= REG_WDATA_IN[5:0];
        `ADDR_POLARITY: pol_q <= REG_WDATA_IN[5:0];
        `ADDR_DRIVE: drive_q <= REG_WDATA_IN[5:0];
        default: ;
      endcase
    end
  end

  // unmapped offsets read as zero
  always_comb begin
    case (REG_ADDR_IN)
      `ADDR_BEH_LOW: rdata_d = beh_lo_q;
      `ADDR_BEH_HIGH: rdata_d = beh_hi_q;
      `ADDR_PULSE_ONCE_PERIOD_FIELD: rdata_d = pulse_once_period_field_q;
      `ADDR_P2_PER: rdata_d = p2_per_q;
      `ADDR_BR_PER: rdata_d = br_per_q;
      `ADDR_LED_CFG: rdata_d = cfg_q;
      `ADDR_DUTY_P1: rdata_d = duty_q[0];
      `ADDR_DUTY_P2: rdata_d = duty_q[1];
      `ADDR_DUTY_BR: rdata_d = duty_q[2];
      `ADDR_DUTY_DR: rdata_d = duty_q[3];
      `ADDR_LINK: rdata_d = {2'b00, link_q};
      `ADDR_POLARITY: rdata_d = {2'b00, pol_q};
      `ADDR_DRIVE: rdata_d = {2'b00, drive_q};
      `ADDR_STATUS: rdata_d = {2'b00, busy};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= REG_RD_IN ? rdata_d : 8'h00;
    end
  end

  // ==========================================================
  // shared timebase: ramp step tick and PWM slot counter
  // counter width follows STEP_CYC, so a longer step cannot wrap early
  localparam int STEP_W = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
  logic [STEP_W-1:0] step_cnt_q;
  logic [6:0] pwm_q;
  wire step_tick = (step_cnt_q == STEP_W'(STEP_CYC - 1));
  wire [11:0] ctl_all = {beh_hi_q[3:0], beh_lo_q};

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      step_cnt_q <= '0;
      pwm_q <= 7'h00;
    end else begin
      step_cnt_q <= step_tick ? '0 : step_cnt_q + STEP_W'(1);
      // one PWM slot per clock: the fastest rate the duty scale allows
      pwm_q <= (pwm_q == `PWM_STEPS - 7'd1) ? 7'h00 : pwm_q + 7'h01;
    end
  end

  // ==========================================================
  // channels
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    chan_state_t st_q, st_d;
    logic src_prev_q;
    logic [8:0] pos_q, pos_d;
    logic [6:0] pre_q, pre_d;
    logic [3:0] left_q, left_d;
    logic [6:0] lat_per_q;
    logic [7:0] lat_duty_q;
    logic go;

    wire behavior_t sel = behavior_t'(ctl_all[2*i +: 2]);
    wire src = link_q[i] ? TOUCH_IN[i] : drive_q[i];
    // the previous level spans link changes, so a dead new source shows as a release
    wire rise = src & ~src_prev_q;
    wire fall = ~src & src_prev_q;
    wire start_once = pulse_once_period_field_q[`P1_TRIG_BIT] ? fall : rise;
    wire [6:0] live_per = (sel == BEH_PULSE_ONCE) ? pulse_once_period_field_q[6:0] :
                          (sel == BEH_PULSE_HELD) ? p2_per_q[6:0] : br_per_q[6:0];
    wire [1:0] duty_idx = (sel == BEH_DIRECT) ? 2'd3 : 2'(sel - 2'd1);
    wire [7:0] live_duty = duty_q[duty_idx];
    wire [2:0] once_cnt = cfg_q[`ONCE_CNT_LSB +: 3];
    wire [2:0] held_cnt = cfg_q[`HELD_CNT_LSB +: 3];
    // direct duty applies live; ramped behaviors of an unlinked channel keep their snapshot
    // an idle channel shows the live minimum, so the snapshot binds only while busy (ST_RUN or ST_COUNT)
    wire frozen = ~link_q[i] & (sel != BEH_DIRECT) & (st_q != ST_IDLE);
    wire [6:0] eff_per = frozen ? lat_per_q : live_per;
    wire [7:0] eff_duty = frozen ? lat_duty_q : live_duty;
    wire [6:0] per = (eff_per < MIN_PER_SETTING) ? MIN_PER_SETTING : eff_per;
    // at or past the end, so a live period cut below the prescaler cannot stretch a step
    wire pre_end = (pre_q >= per - 7'd1);
    wire wrap = step_tick & pre_end & (pos_q == 9'h1FF);
    wire [6:0] dmin = min_pct(eff_duty[3:0]);
    wire [6:0] dmax = max_pct(eff_duty[7:4]);
    wire [6:0] span = (dmax > dmin) ? dmax - dmin : 7'd0;
    wire [7:0] lvl = pos_q[8] ? ~pos_q[7:0] : pos_q[7:0];
    wire [14:0] scaled = span * lvl;
    wire [6:0] ramp = dmin + scaled[14:8];
    wire [6:0] duty_now = (st_q == ST_IDLE) ? dmin :
                          (sel == BEH_DIRECT) ? dmax : ramp;
    wire on = (pwm_q < duty_now);

    // pin level for "on" set by polarity; idle still drives the minimum duty dmin, not a fixed off level
    assign led_d[i] = pol_q[i] ? on : ~on;
    assign busy[i] = (st_q != ST_IDLE);

    always_comb begin
      st_d = st_q;
      left_d = left_q;
      go = 1'b0;
      case (st_q)
        ST_IDLE: begin
          case (sel)
            BEH_DIRECT: begin
              if (rise) begin
                st_d = ST_RUN;
              end
            end
            BEH_PULSE_ONCE: begin
              if (start_once) begin
                st_d = ST_COUNT;
                left_d = {1'b0, once_cnt} + 4'd1;
                go = 1'b1;
              end
            end
            default: begin
              if (rise) begin
                st_d = ST_RUN;
                go = 1'b1;
              end
            end
          endcase
        end
        ST_RUN: begin
          case (sel)
            BEH_PULSE_ONCE: begin
              // select changed under a running channel: finish as a counted pulse train
              st_d = ST_COUNT;
              left_d = {1'b0, once_cnt} + 4'd1;
            end
            BEH_PULSE_HELD: begin
              if (fall) begin
                st_d = ST_COUNT;
                left_d = {1'b0, held_cnt} + 4'd1;
              end
            end
            default: begin
              if (fall) begin
                st_d = ST_IDLE;
              end
            end
          endcase
        end
        ST_COUNT: begin
          if (sel == BEH_DIRECT || sel == BEH_BREATHE) begin
            st_d = src ? ST_RUN : ST_IDLE;
          end else if (sel == BEH_PULSE_HELD && rise) begin
            // a new touch during the tail resumes holding, with a fresh snapshot
            st_d = ST_RUN;
            go = 1'b1;
          end else if (wrap) begin
            // pulse once does not look at the source until the last pulse ends
            if (left_q == 4'd1) begin
              st_d = ST_IDLE;
            end else begin
              left_d = left_q - 4'd1;
            end
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end

    // 512 steps of per step ticks make one pulse of per x 32 ms
    always_comb begin
      pos_d = pos_q;
      pre_d = pre_q;
      if (go || st_q == ST_IDLE) begin
        pos_d = 9'h000;
        pre_d = 7'h00;
      end else if (step_tick) begin
        pre_d = pre_end ? 7'h00 : pre_q + 7'h01;
        pos_d = pre_end ? pos_q + 9'h001 : pos_q;
      end
    end

    always_ff @(posedge CORE_CLK_IN) begin
      if (SYS_RST_IN) begin
        st_q <= ST_IDLE;
        src_prev_q <= 1'b0;
        pos_q <= 9'h000;
        pre_q <= 7'h00;
        left_q <= 4'h0;
        lat_per_q <= 7'h00;
        lat_duty_q <= 8'h00;
      end else begin
        st_q <= st_d;
        src_prev_q <= src;
        pos_q <= pos_d;
        pre_q <= pre_d;
        left_q <= left_d;
        if (go) begin
          lat_per_q <= live_per;
          lat_duty_q <= live_duty;
        end
      end
    end
  end

  // ==========================================================
  // outputs
  // pins come from flops so a decode glitch never reaches an LED
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      led_q <= 6'h00;
    end else begin
      led_q <= led_d;
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign LED_OUT = led_q;

endmodule // led_behavior_sequencer

`default_nettype wire

// >>> shared/led_seq_defs.svh
/*
  Register offsets, field positions, reset values and timing counts of the LED behavior sequencer.
  Assumes inclusion by bare name from a design or bench file; definitions only.
*/
`ifndef LED_SEQ_DEFS_SVH
`define LED_SEQ_DEFS_SVH

// ==========================================================
// register offsets
`define ADDR_LINK 8'h72
`define ADDR_POLARITY 8'h73
`define ADDR_DRIVE 8'h74
`define ADDR_STATUS 8'h75
`define ADDR_BEH_LOW 8'h81
`define ADDR_BEH_HIGH 8'h82
`define ADDR_PULSE_ONCE_PERIOD_FIELD 8'h84
`define ADDR_P2_PER 8'h85
`define ADDR_BR_PER 8'h86
`define ADDR_LED_CFG 8'h88
`define ADDR_DUTY_P1 8'h90
`define ADDR_DUTY_P2 8'h91
`define ADDR_DUTY_BR 8'h92
`define ADDR_DUTY_DR 8'h93

// ==========================================================
// reset values
`define RST_BEH 8'h00
`define RST_PULSE_ONCE_PERIOD_FIELD 8'h20
`define RST_P2_PER 8'h14
`define RST_BR_PER 8'h5D
`define RST_LED_CFG 8'h04
`define RST_DUTY 8'hF0
`define RST_CHAN 6'h00

// ==========================================================
// field positions
`define P1_TRIG_BIT 7
`define PER_MSB 6
`define ONCE_CNT_LSB 0
`define HELD_CNT_LSB 3

// ==========================================================
// timing: one ramp step is 1/512 of a 32 ms period unit
`define PER_UNIT_MS 32
`define STEP_TIME_NS 62500
`define CLK_MHZ 250
`define STEP_CYCLES ((`STEP_TIME_NS * `CLK_MHZ) / 1000)
`define PWM_STEPS 7'd100

`endif

// >>> shared/led_seq_pkg.sv
/*
  Types of the LED behavior sequencer: channel states and behavior codes.
  Assumes nothing of its surroundings.
*/
package led_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_COUNT = 2'b10
  } chan_state_t;

  typedef enum logic [1:0] {
    BEH_DIRECT = 2'b00,
    BEH_PULSE_ONCE = 2'b01,
    BEH_PULSE_HELD = 2'b10,
    BEH_BREATHE = 2'b11
  } behavior_t;
endpackage

// >>> dv/led_behavior_sequencer_properties.sv
/*
  Checker for the LED behavior sequencer: register read data and reset output level.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module led_seq_props (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic [5:0] TOUCH_IN,
  input wire logic [5:0] LED_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ==========================================================
  // decode
  wire unmapped = !(REG_ADDR_IN inside {8'h72, 8'h73, 8'h74, 8'h75, 8'h81, 8'h82, 8'h84, 8'h85, 8'h86, 8'h88,
    8'h90, 8'h91, 8'h92, 8'h93});
  wire rd_ctl = REG_RD_IN && (REG_ADDR_IN inside {8'h72, 8'h73, 8'h74});
  wire wr_beh = REG_WR_IN && REG_ADDR_IN == 8'h81;
  wire rd_beh = REG_RD_IN && REG_ADDR_IN == 8'h81;
  wire wr_per1 = REG_WR_IN && REG_ADDR_IN == 8'h84;
  wire rd_per1 = REG_RD_IN && REG_ADDR_IN == 8'h84;
  // ==========================================================
  // assertions
  a_rdata_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (REG_RD_IN && unmapped |=> REG_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_high_nibble: assert property (REG_RD_IN && REG_ADDR_IN == 8'h82 |=> REG_RDATA_OUT[7:4] == 4'h0)
    else $error("upper behavior nibble not zero");
  a_period_msb: assert property (REG_RD_IN && REG_ADDR_IN inside {8'h85, 8'h86} |=> !REG_RDATA_OUT[7])
    else $error("period bit 7 not zero");
  a_low_readback: assert property (wr_beh ##1 !wr_beh ##1 rd_beh
    |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
    else $error("behavior select readback wrong");
  a_trig_readback: assert property (wr_per1 ##1 !wr_per1 ##1 rd_per1
    |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
    else $error("pulse once period readback wrong");
  a_cfg_mask: assert property (REG_RD_IN && REG_ADDR_IN == 8'h88 |=> REG_RDATA_OUT[7:6] == 2'b00)
    else $error("count register top bits not zero");
  a_ctrl_mask: assert property (rd_ctl |=> REG_RDATA_OUT[7:6] == 2'b00)
    else $error("channel bit register top bits not zero");
  a_led_reset: assert property ($fell(SYS_RST_IN) |-> LED_OUT == 6'h00)
    else $error("pins not cleared by reset");
  // ==========================================================
  // covers
  c_read: cover property (REG_RD_IN && REG_ADDR_IN == 8'h75);
  c_drive: cover property (REG_WR_IN && REG_ADDR_IN == 8'h74);
  c_touch: cover property ($rose(TOUCH_IN[5]));
endmodule // led_seq_props
bind led_behavior_sequencer led_seq_props u_props (.CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .TOUCH_IN(TOUCH_IN), .LED_OUT(LED_OUT));
`default_nettype wire

// >>> dv/touch_source_model.sv
/*
  Touch logic model: presents requested touch flags promptly or three cycles late.
  Assumes the same clock and reset as the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_source_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [5:0] want_in,
  input wire logic slow_in,
  output logic [5:0] touch_out
);
  logic [5:0] d1_q;
  logic [5:0] d2_q;
  // ==========================================================
  // touch flags, a slow sensor lags by detection time
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      d1_q <= 6'h00;
      d2_q <= 6'h00;
      touch_out <= 6'h00;
    end else begin
      d1_q <= want_in;
      d2_q <= d1_q;
      touch_out <= slow_in ? d2_q : want_in;
    end
  end
endmodule // touch_source_model
`default_nettype wire

// >>> dv/led_behavior_sequencer_tb.sv
/*
  Self-checking bench of the LED behavior sequencer, with a touch logic model.
  Assumes a short step count so that a 32 ms unit lasts 1024 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module led_behavior_sequencer_tb import led_seq_pkg::*;;
  localparam int STEP = 2;
  localparam int P = 512 * STEP;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [5:0] want = 6'h00;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic [5:0] touch;
  logic [5:0] led;
  logic [7:0] r;
  logic [7:0] exp_q[$];
  string nm_q[$];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  logic [15:0] rst_tab [12] = '{16'h8100, 16'h8200, 16'h8420, 16'h8514, 16'h865D, 16'h8804, 16'h90F0,
    16'h93F0, 16'h7200, 16'h7400, 16'h7500, 16'h8300};
  led_behavior_sequencer #(.STEP_CYC(STEP)) dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .TOUCH_IN(touch), .LED_OUT(led));
  touch_source_model partner (.clk_in(clk), .rst_in(rst), .want_in(want), .slow_in(slow), .touch_out(touch));
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_to(input int t);
    while (cyc < t) @(posedge clk);
  endtask
  // pwm at 0% or 100% holds the pin for a whole frame
  task automatic led_hold(input logic v);
    idle(4);
    repeat (100) begin
      @(negedge clk);
      check("led0", {7'h00, led[0]}, {7'h00, v});
    end
  endtask
  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // result monitor: read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_seen) check(nm_q.pop_front(), rdata, exp_q.pop_front());
    rd_seen <= rd;
  end
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'hEB9654F4));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rst_tab[k]) rd_reg(rst_tab[k][15:8], rst_tab[k][7:0], "reset");
    $display("test reset_values done");
    wr_reg(8'h82, 8'hFF);
    rd_reg(8'h82, 8'h0F, "beh_high");
    wr_reg(8'h85, 8'hFF);
    rd_reg(8'h85, 8'h7F, "held_per");
    wr_reg(8'h83, 8'h5A);
    rd_reg(8'h83, 8'h00, "unmapped");
    wr_reg(8'h75, 8'hFF);
    rd_reg(8'h75, 8'h00, "status");
    repeat (4) begin
      r = 8'($urandom);
      wr_reg(8'h81, r);
      rd_reg(8'h81, r, "beh_low");
      r = 8'($urandom);
      wr_reg(8'h84, r);
      rd_reg(8'h84, r, "pulse_once_period_field");
    end
    wr_reg(8'h82, 8'h00);
    wr_reg(8'h85, 8'h01);
    wr_reg(8'h88, 8'h00);
    $display("test register_access done");
    // pulse once, setting 00h lasts one unit, toggles mid-train are forgotten
    wr_reg(8'h81, 8'h01);
    wr_reg(8'h84, 8'h00);
    wr_reg(8'h74, 8'h01);
    t0 = cyc;
    idle(300);
    wr_reg(8'h74, 8'h00);
    wr_reg(8'h74, 8'h01);
    wait_to(t0 + P - 80);
    rd_reg(8'h75, 8'h01, "once_busy");
    wait_to(t0 + P + 80);
    rd_reg(8'h75, 8'h00, "once_done");
    wr_reg(8'h74, 8'h00);
    wr_reg(8'h84, 8'h80);
    wr_reg(8'h74, 8'h01);
    idle(10);
    rd_reg(8'h75, 8'h00, "trig_set");
    wr_reg(8'h74, 8'h00);
    idle(10);
    rd_reg(8'h75, 8'h01, "trig_clear");
    idle(P + 60);
    rd_reg(8'h75, 8'h00, "trig_done");
    $display("test pulse_once done");
    // pulse while held; a period write after the start must not stretch the tail
    wr_reg(8'h81, 8'h08);
    wr_reg(8'h74, 8'h02);
    wr_reg(8'h85, 8'h7F);
    idle(2 * P);
    rd_reg(8'h75, 8'h02, "held_run");
    wr_reg(8'h74, 8'h00);
    idle(20);
    rd_reg(8'h75, 8'h02, "held_tail");
    idle(P + 100);
    rd_reg(8'h75, 8'h00, "held_done");
    // setting the drive bit again during the tail resumes holding
    wr_reg(8'h85, 8'h01);
    wr_reg(8'h74, 8'h02);
    idle(20);
    wr_reg(8'h74, 8'h00);
    idle(20);
    wr_reg(8'h74, 8'h02);
    idle(P + 100);
    rd_reg(8'h75, 8'h02, "held_again");
    wr_reg(8'h74, 8'h00);
    idle(P + 100);
    rd_reg(8'h75, 8'h00, "held_end");
    $display("test pulse_held done");
    wr_reg(8'h82, 8'h0C);
    wr_reg(8'h72, 8'h20);
    @(posedge clk);
    want <= 6'h20;
    slow <= 1'b1;
    idle(10);
    rd_reg(8'h75, 8'h20, "breathe_on");
    want <= 6'h00;
    idle(10);
    rd_reg(8'h75, 8'h00, "breathe_off");
    wr_reg(8'h72, 8'h00);
    $display("test linked_breathe done");
    // direct on channel 0, then swap its source back and forth
    wr_reg(8'h81, 8'h00);
    wr_reg(8'h74, 8'h01);
    idle(4);
    rd_reg(8'h75, 8'h01, "direct_on");
    led_hold(1'b0);
    wr_reg(8'h72, 8'h01);
    idle(4);
    rd_reg(8'h75, 8'h00, "link_release");
    led_hold(1'b1);
    @(posedge clk);
    want <= 6'h01;
    slow <= 1'b0;
    idle(6);
    rd_reg(8'h75, 8'h01, "touch_on");
    wr_reg(8'h73, 8'h01);
    led_hold(1'b1);
    @(posedge clk);
    want <= 6'h00;
    idle(6);
    rd_reg(8'h75, 8'h00, "touch_off");
    led_hold(1'b0);
    wr_reg(8'h72, 8'h00);
    idle(4);
    rd_reg(8'h75, 8'h01, "unlink_follow");
    wr_reg(8'h74, 8'h00);
    idle(4);
    $display("test direct_link done");
    conclude();
  end
endmodule // led_behavior_sequencer_tb
`default_nettype wire
